// ### vmcr_host_model.sv
// Host-side model that issues single-cycle command requests to the bank.
// Assumes the bank samples req on the rising clk edge, one edge per request.
`timescale 1ns/1ps
module vmcr_host_model
  import vmcr_pkg::*;
(
  // Clock
  input  wire logic clk,
  // Request to the bank
  output vmcr_req_t req
);
  initial req = '0;

  // Write strobe; a released bus shows inverted lines, not stale ones
  task automatic wr(input logic [7:0] code, input logic [15:0] data);
    @(posedge clk);
    req <= '{valid: 1'b1, write: 1'b1, code: code, wdata: data};
    @(posedge clk);
    req <= '{valid: 1'b0, write: 1'b0, code: ~code, wdata: ~data};
  endtask

  // Read strobe; the answer is registered on the same edge that takes it
  task automatic rd(input logic [7:0] code);
    @(posedge clk);
    req <= '{valid: 1'b1, write: 1'b0, code: code, wdata: 16'hFFFF};
    @(posedge clk);
    req <= '{valid: 1'b0, write: 1'b1, code: ~code, wdata: 16'h0000};
  endtask
endmodule

// ### vmcr_pkg.sv
// Shared constants and carrier types for the regulator config bank.
// Assumes one 40 MHz clock domain and an upstream PMBus framer.
package vmcr_pkg;

  // Command codes of the bank
  localparam logic [7:0] CMD_CURRENT_LIMIT = 8'hD0;
  localparam logic [7:0] CMD_AVG_TIME      = 8'hD1;
  localparam logic [7:0] CMD_VOUT_READBACK = 8'hD4;
  localparam logic [7:0] CMD_TRIM_OFFSET   = 8'hD5;
  localparam logic [7:0] CMD_ADD_FUNC      = 8'hD7;
  localparam logic [7:0] CMD_DROOP_SCALE   = 8'hD8;

  // Reset values
  localparam logic [3:0] RST_LIMIT_CODE = 4'h8;
  localparam logic [7:0] RST_AVG_TIME   = 8'h50;
  localparam logic [7:0] RST_TRIM       = 8'h00;
  localparam logic [7:0] RST_ADD_FUNC   = 8'h02;
  localparam logic [7:0] RST_DROOP      = 8'h04;

  // Writable field masks
  localparam logic [7:0] MASK_LIMIT    = 8'h0F;
  localparam logic [7:0] MASK_AVG_TIME = 8'h73;
  localparam logic [7:0] MASK_ADD_FUNC = 8'h07;

  // Field positions
  localparam int POS_PIN_AVG_LSB   = 4;
  localparam int POS_IV_AVG_LSB    = 0;
  localparam int POS_FAST_SLEW     = 2;
  localparam int POS_BODY_BRAKING  = 1;
  localparam int POS_SOFT_START    = 0;

  // Electrical scale constants
  localparam logic [6:0]  LIMIT_BASE_AMPS  = 7'h18;
  localparam logic [6:0]  LIMIT_STEP_AMPS  = 7'h03;
  localparam logic [3:0]  LIMIT_TOP_CODE   = 4'hE;
  localparam logic signed [11:0] TRIM_STEP_FIRST_MV  = 12'sh005;
  localparam logic signed [11:0] TRIM_STEP_SECOND_MV = 12'sh00A;
  localparam logic [10:0] SLEW_ADD_UV_PER_US = 11'h550;
  localparam logic [1:0]  STRAP_SETTLE_CYCLES = 2'h2;

  // Decoded configuration handed to the control loop
  typedef struct packed {
    logic [6:0]         valley_limit_amps;
    logic [8:0]         pin_avg_half_ms;
    logic [4:0]         iv_avg_tenth_ms;
    logic signed [11:0] trim_mv;
    logic [10:0]        slew_add_uv_per_us;
    logic               body_braking_select;
    logic               soft_start_slew_select;
    logic [7:0]         droop_pct;
  } vmcr_cfg_t;

  // Register access request from the framer
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [7:0]  code;
    logic [15:0] wdata;
  } vmcr_req_t;

endpackage

// ### vmcr_regs.sv
// Manufacturer config and telemetry register bank of the regulator.
// Assumes a PMBus framer on clk hands over decoded command requests,
// and that telemetry mantissa comes from logic on the same clock.
// Function
// - The current limit register keeps a 4-bit code in bits 3:0, upper bits read zero, 24 A plus 3 A per step up to 66 A at code Eh.
// - Bits 6:4 of the averaging register choose the input power window from bypass up to 225 ms.
// - Bits 1:0 of the averaging register choose bypass, 0.5 ms, 1 ms or 2.5 ms for current and voltage.
// - The averaging register resets to 50h with bit 7 and bits 3:2 reading zero.
// - The readback register is read-only and returns the 16-bit mantissa of measured output voltage.
// - The trim register is a signed 8-bit offset worth 5 mV or 10 mV per step by table.
// - Trim code 7Fh means 0.635 V or 1.27 V and 7Eh means 0.630 V or 1.26 V.
// - The trim register resets to 00h meaning no offset.
// - Fast slew bit 2 adds 1.36 mV/us to the selected slew rate when set.
// - Bit 1 chooses overshoot truncation without or with body braking.
// - Bit 0 makes soft start follow the rise time or one sixteenth of the slew rate.
// - The function register resets to 02h and bits 7:3 read zero.
// - The droop register scales the load line slope in percent and resets to 04h.
// - The limit code starts from the strap pin or from 08h, and a write overrides the strap.
`timescale 1ns/1ps
module vmcr_regs
  import vmcr_pkg::*;
#(
  parameter int MANT_WIDTH = 16
) (
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  reset_n,
  // Command port from the framer
  input  wire vmcr_req_t             req,
  output logic [15:0]                rdata_r,
  output logic                       rvalid_r,
  output logic                       cmd_error_r,
  // Strap pins and table select
  input  wire logic                  strap_present,
  input  wire logic [3:0]            current_limit_strap_pin,
  input  wire logic                  second_vid_table,
  // Telemetry input
  input  wire logic [MANT_WIDTH-1:0] vout_linear_mantissa,
  // Decoded configuration
  output vmcr_cfg_t                  cfg_r
);

  // Only a 16-bit mantissa is served; refused at elaboration
  if (MANT_WIDTH != 16) begin : g_bad_mant
    $error("vmcr_regs supports a 16-bit mantissa only");
  end

  // Valley limit in amps; top codes clamp at 66 A
  function automatic logic [6:0] limit_amps(input logic [3:0] code);
    logic [3:0] c;
    c = (code > LIMIT_TOP_CODE) ? LIMIT_TOP_CODE : code;
    return 7'(LIMIT_BASE_AMPS + 7'(c) * LIMIT_STEP_AMPS);
  endfunction

  // Input power window in half milliseconds
  function automatic logic [8:0] pin_window(input logic [2:0] sel);
    case (sel)
      3'h0:    return 9'h000;
      3'h1:    return 9'h004;
      3'h2:    return 9'h00B;
      3'h3:    return 9'h017;
      3'h4:    return 9'h026;
      3'h5:    return 9'h064;
      3'h6:    return 9'h0C8;
      default: return 9'h1C2;
    endcase
  endfunction

  // Current and voltage window in tenths of a millisecond
  function automatic logic [4:0] iv_window(input logic [1:0] sel);
    case (sel)
      2'h0:    return 5'h00;
      2'h1:    return 5'h05;
      2'h2:    return 5'h0A;
      default: return 5'h19;
    endcase
  endfunction

  // Load line scale; unlisted codes fall back to nominal
  function automatic logic [7:0] droop_pct(input logic [7:0] code);
    case (code)
      8'h00:   return 8'h00;
      8'h01:   return 8'h19;
      8'h02:   return 8'h32;
      8'h03:   return 8'h4B;
      8'h10:   return 8'h50;
      8'h20:   return 8'h55;
      8'h30:   return 8'h5A;
      8'h40:   return 8'h5F;
      8'h50:   return 8'h69;
      8'h60:   return 8'h6E;
      8'h70:   return 8'h73;
      8'h80:   return 8'h78;
      8'h90:   return 8'h7D;
      8'hA0:   return 8'h96;
      8'hB0:   return 8'hAF;
      default: return 8'h64;
    endcase
  endfunction

  logic [4:0] strap_sync;
  logic [3:0] limit_r,  limit_nxt;
  logic [7:0] avg_r,    avg_nxt;
  logic [7:0] trim_r,   trim_nxt;
  logic [7:0] func_r,   func_nxt;
  logic [7:0] droop_r,  droop_nxt;
  logic [15:0] vout_r,  vout_nxt;
  logic        limit_wr_r, limit_wr_nxt;
  logic [1:0]  settle_r, settle_nxt;
  logic        strap_done_r, strap_done_nxt;
  logic [15:0] rdata_nxt;
  logic        rvalid_nxt;
  logic        cmd_error_nxt;
  vmcr_cfg_t   cfg_nxt;
  logic        wr;
  logic        rd;

  // Strap pins are asynchronous levels
  vmcr_sync #(
    .WIDTH (5)
  ) u_strap_sync (
    .clk      (clk),
    .reset_n  (reset_n),
    .pin_in   ({strap_present, current_limit_strap_pin}),
    .sync_out (strap_sync)
  );

  assign wr = req.valid & req.write;
  assign rd = req.valid & ~req.write;

  // Register storage next values
  always_comb begin
    limit_nxt      = limit_r;
    avg_nxt        = avg_r;
    trim_nxt       = trim_r;
    func_nxt       = func_r;
    droop_nxt      = droop_r;
    limit_wr_nxt   = limit_wr_r;
    settle_nxt     = settle_r;
    strap_done_nxt = strap_done_r;
    // Telemetry sampled every cycle so reads see a fresh value
    vout_nxt       = vout_linear_mantissa;
    if (!strap_done_r) begin
      if (settle_r == STRAP_SETTLE_CYCLES) begin
        strap_done_nxt = 1'b1;
        if (strap_sync[4] && !limit_wr_r) begin
          limit_nxt = strap_sync[3:0];
        end
      end else begin
        settle_nxt = 2'(settle_r + 2'h1);
      end
    end
    if (wr) begin
      case (req.code)
        CMD_CURRENT_LIMIT: begin
          limit_nxt    = req.wdata[3:0] & MASK_LIMIT[3:0];
          limit_wr_nxt = 1'b1;
        end
        CMD_AVG_TIME:    avg_nxt   = req.wdata[7:0] & MASK_AVG_TIME;
        CMD_TRIM_OFFSET: trim_nxt  = req.wdata[7:0];
        CMD_ADD_FUNC:    func_nxt  = req.wdata[7:0] & MASK_ADD_FUNC;
        CMD_DROOP_SCALE: droop_nxt = req.wdata[7:0];
        default: begin
        end
      endcase
    end
  end

  // Register storage
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      limit_r      <= RST_LIMIT_CODE;
      avg_r        <= RST_AVG_TIME;
      trim_r       <= RST_TRIM;
      func_r       <= RST_ADD_FUNC;
      droop_r      <= RST_DROOP;
      vout_r       <= 16'h0000;
      limit_wr_r   <= 1'b0;
      settle_r     <= 2'h0;
      strap_done_r <= 1'b0;
    end else begin
      limit_r      <= limit_nxt;
      avg_r        <= avg_nxt;
      trim_r       <= trim_nxt;
      func_r       <= func_nxt;
      droop_r      <= droop_nxt;
      vout_r       <= vout_nxt;
      limit_wr_r   <= limit_wr_nxt;
      settle_r     <= settle_nxt;
      strap_done_r <= strap_done_nxt;
    end
  end

  // Read answer and error flag; writes to readback count as errors
  always_comb begin
    rdata_nxt     = 16'h0000;
    rvalid_nxt    = rd;
    cmd_error_nxt = 1'b0;
    if (req.valid) begin
      case (req.code)
        CMD_CURRENT_LIMIT: rdata_nxt = {12'h000, limit_r};
        CMD_AVG_TIME:      rdata_nxt = {8'h00, avg_r};
        CMD_VOUT_READBACK: begin
          rdata_nxt     = vout_r;
          cmd_error_nxt = req.write;
        end
        CMD_TRIM_OFFSET:   rdata_nxt = {8'h00, trim_r};
        CMD_ADD_FUNC:      rdata_nxt = {8'h00, func_r};
        CMD_DROOP_SCALE:   rdata_nxt = {8'h00, droop_r};
        default:           cmd_error_nxt = 1'b1;
      endcase
    end
    if (!rd) begin
      rdata_nxt = rdata_r;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata_r     <= 16'h0000;
      rvalid_r    <= 1'b0;
      cmd_error_r <= 1'b0;
    end else begin
      rdata_r     <= rdata_nxt;
      rvalid_r    <= rvalid_nxt;
      cmd_error_r <= cmd_error_nxt;
    end
  end

  // Decoded configuration, registered so outputs come from flops
  always_comb begin
    cfg_nxt.valley_limit_amps = limit_amps(limit_r);
    cfg_nxt.pin_avg_half_ms = pin_window(avg_r[POS_PIN_AVG_LSB +: 3]);
    cfg_nxt.iv_avg_tenth_ms = iv_window(avg_r[POS_IV_AVG_LSB +: 2]);
    cfg_nxt.trim_mv = 12'(signed'({{4{trim_r[7]}}, trim_r})
                      * (second_vid_table ? TRIM_STEP_SECOND_MV : TRIM_STEP_FIRST_MV));
    cfg_nxt.slew_add_uv_per_us = func_r[POS_FAST_SLEW] ? SLEW_ADD_UV_PER_US : 11'h000;
    cfg_nxt.body_braking_select = func_r[POS_BODY_BRAKING];
    cfg_nxt.soft_start_slew_select = func_r[POS_SOFT_START];
    cfg_nxt.droop_pct = droop_pct(droop_r);
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cfg_r <= '0;
    end else begin
      cfg_r <= cfg_nxt;
    end
  end

  // Checks on the bank
  a_limit_amps: assert property (@(posedge clk) disable iff (!reset_n)
    limit_r == 4'h1 |=> cfg_r.valley_limit_amps == 7'h1B)
    else $error("limit code 1 not decoded to 27 A");
  a_limit_clamp: assert property (@(posedge clk) disable iff (!reset_n)
    limit_r == 4'hF |=> cfg_r.valley_limit_amps == 7'h42)
    else $error("limit code F not decoded to 66 A");
  a_limit_write: assert property (@(posedge clk) disable iff (!reset_n)
    wr && req.code == CMD_CURRENT_LIMIT |=> limit_r == $past(req.wdata[3:0]))
    else $error("limit write not taken");
  a_avg_reserved: assert property (@(posedge clk) disable iff (!reset_n)
    (avg_r & ~MASK_AVG_TIME) == 8'h00)
    else $error("averaging reserved bits set");
  a_pin_window: assert property (@(posedge clk) disable iff (!reset_n)
    avg_r[6:4] == 3'h7 |=> cfg_r.pin_avg_half_ms == 9'h1C2)
    else $error("input power window code 7 not 225 ms");
  a_iv_window: assert property (@(posedge clk) disable iff (!reset_n)
    avg_r[1:0] == 2'h3 |=> cfg_r.iv_avg_tenth_ms == 5'h19)
    else $error("iv window code 3 not 2.5 ms");
  a_read_vout: assert property (@(posedge clk) disable iff (!reset_n)
    rd && req.code == CMD_VOUT_READBACK |=> rvalid_r && rdata_r == $past(vout_r))
    else $error("readback did not return mantissa");
  a_trim_max: assert property (@(posedge clk) disable iff (!reset_n)
    trim_r == 8'h7F && second_vid_table |=> cfg_r.trim_mv == 12'sh4F6)
    else $error("trim max not 1.27 V");
  a_trim_first: assert property (@(posedge clk) disable iff (!reset_n)
    trim_r == 8'h7E && !second_vid_table |=> cfg_r.trim_mv == 12'sh276)
    else $error("trim step not 5 mV");
  a_fast_slew: assert property (@(posedge clk) disable iff (!reset_n)
    func_r[2] |=> cfg_r.slew_add_uv_per_us == 11'h550)
    else $error("fast slew add missing");
  a_func_reserved: assert property (@(posedge clk) disable iff (!reset_n)
    func_r[7:3] == 5'h00)
    else $error("function reserved bits set");
  a_func_bits: assert property (@(posedge clk) disable iff (!reset_n)
    1'b1 |=> cfg_r.body_braking_select == $past(func_r[1])
             && cfg_r.soft_start_slew_select == $past(func_r[0]))
    else $error("function bit decode wrong");
  a_droop_half: assert property (@(posedge clk) disable iff (!reset_n)
    droop_r == 8'h02 |=> cfg_r.droop_pct == 8'h32)
    else $error("droop 50 percent wrong");

endmodule

// ### vmcr_regs_tb.sv
// Self-checking bench for the regulator config bank.
// Assumes the host model drives req; telemetry and straps come from here.
`timescale 1ns/1ps
module vmcr_regs_tb;
  import vmcr_pkg::*;
  logic        clk;
  logic        reset_n;
  logic        strap_present;
  logic        second_vid_table;
  logic [3:0]  strap_code;
  logic [15:0] mant;
  vmcr_req_t   req;
  logic [15:0] rdata_r;
  logic        rvalid_r;
  logic        cmd_error_r;
  vmcr_cfg_t   cfg_r;
  int          err_count;
  int          n_tests;
  int          i;
  logic [8:0]  pin_tab [8] = '{9'h000, 9'h004, 9'h00B, 9'h017, 9'h026, 9'h064, 9'h0C8, 9'h1C2};
  logic [4:0]  iv_tab [4]  = '{5'h00, 5'h05, 5'h0A, 5'h19};
  logic [7:0]  dr_in [5]   = '{8'h02, 8'hB0, 8'h05, 8'h00, 8'h10};
  logic [7:0]  dr_pct [5]  = '{8'h32, 8'hAF, 8'h64, 8'h00, 8'h50};

  vmcr_host_model host (.clk(clk), .req(req));

  vmcr_regs #(.MANT_WIDTH(16)) uut (
    .clk(clk), .reset_n(reset_n), .req(req), .rdata_r(rdata_r), .rvalid_r(rvalid_r),
    .cmd_error_r(cmd_error_r), .strap_present(strap_present),
    .current_limit_strap_pin(strap_code), .second_vid_table(second_vid_table),
    .vout_linear_mantissa(mant), .cfg_r(cfg_r)
  );

  // Free-running 40 MHz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Read, then look at the one-cycle answer once it has settled
  task automatic rd_chk(input logic [7:0] code, input logic [15:0] exp);
    host.rd(code);
    #1;
    check({15'h0000, rvalid_r}, 16'h0001);
    check(rdata_r, exp);
  endtask

  // Write, then wait the extra edge the decoded outputs need
  task automatic wr_cfg(input logic [7:0] code, input logic [15:0] data);
    host.wr(code, data);
    @(posedge clk);
    #1;
  endtask

  task automatic do_reset;
    @(posedge clk) reset_n <= 1'b0;
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    repeat (5) @(posedge clk);
    #1;
  endtask

  task automatic give_verdict;
    $display("Comparisons %0d, mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Watchdog, generous against the roughly 225 cycles of tests
  initial begin
    #(25 * 6000);
    err_count++;
    give_verdict();
  end

  // Main sequence
  initial begin
    reset_n = 1'b0;
    strap_present = 1'b0;
    second_vid_table = 1'b0;
    strap_code = 4'h3;
    mant = 16'hA5C3;
    err_count = 0;
    n_tests = 0;
    do_reset();
    check({9'h000, cfg_r.valley_limit_amps}, 16'h0030);
    check({7'h00, cfg_r.pin_avg_half_ms}, 16'h0064);
    check({15'h0000, cfg_r.body_braking_select}, 16'h0001);
    check({8'h00, cfg_r.droop_pct}, 16'h0064);
    rd_chk(CMD_CURRENT_LIMIT, 16'h0008);
    rd_chk(CMD_AVG_TIME, 16'h0050);
    rd_chk(CMD_TRIM_OFFSET, 16'h0000);
    rd_chk(CMD_ADD_FUNC, 16'h0002);
    rd_chk(CMD_DROOP_SCALE, 16'h0004);
    rd_chk(CMD_VOUT_READBACK, 16'hA5C3);
    // Every limit code, with the reserved nibble set on each write
    for (i = 0; i < 16; i++) begin
      wr_cfg(CMD_CURRENT_LIMIT, {8'hFF, 4'hA, 4'(i)});
      check({9'h000, cfg_r.valley_limit_amps},
            (i >= 14) ? 16'h0042 : 16'h0018 + 16'h0003 * 16'(i));
      rd_chk(CMD_CURRENT_LIMIT, 16'(i));
    end
    // Every averaging code, reserved bits written high
    for (i = 0; i < 8; i++) begin
      wr_cfg(CMD_AVG_TIME, {8'h00, 1'b1, 3'(i), 2'b11, 2'(i)});
      check({7'h00, cfg_r.pin_avg_half_ms}, {7'h00, pin_tab[i]});
      check({11'h000, cfg_r.iv_avg_tenth_ms}, {11'h000, iv_tab[i % 4]});
      rd_chk(CMD_AVG_TIME, {9'h000, 3'(i), 2'b00, 2'(i)});
    end
    wr_cfg(CMD_TRIM_OFFSET, 16'h007F);
    check({4'h0, cfg_r.trim_mv}, 16'h027B);
    @(posedge clk) second_vid_table <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    check({4'h0, cfg_r.trim_mv}, 16'h04F6);
    wr_cfg(CMD_TRIM_OFFSET, 16'h007E);
    check({4'h0, cfg_r.trim_mv}, 16'h04EC);
    wr_cfg(CMD_TRIM_OFFSET, 16'h0080);
    check({4'h0, cfg_r.trim_mv}, 16'h0B00);
    @(posedge clk) second_vid_table <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    check({4'h0, cfg_r.trim_mv}, 16'h0D80);
    rd_chk(CMD_TRIM_OFFSET, 16'h0080);
    wr_cfg(CMD_TRIM_OFFSET, 16'h007E);
    check({4'h0, cfg_r.trim_mv}, 16'h0276);
    wr_cfg(CMD_ADD_FUNC, 16'h00FF);
    check({5'h00, cfg_r.slew_add_uv_per_us}, 16'h0550);
    check({15'h0000, cfg_r.soft_start_slew_select}, 16'h0001);
    rd_chk(CMD_ADD_FUNC, 16'h0007);
    wr_cfg(CMD_ADD_FUNC, 16'h0001);
    check({5'h00, cfg_r.slew_add_uv_per_us}, 16'h0000);
    check({15'h0000, cfg_r.body_braking_select}, 16'h0000);
    for (i = 0; i < 5; i++) begin
      wr_cfg(CMD_DROOP_SCALE, {8'h00, dr_in[i]});
      check({8'h00, cfg_r.droop_pct}, {8'h00, dr_pct[i]});
    end
    // Readback is refused on write and follows live telemetry
    host.wr(CMD_VOUT_READBACK, 16'h1234);
    #1;
    check({15'h0000, cmd_error_r}, 16'h0001);
    @(posedge clk) mant <= 16'h8001;
    rd_chk(CMD_VOUT_READBACK, 16'h8001);
    host.rd(8'hD2);
    #1;
    check({15'h0000, cmd_error_r}, 16'h0001);
    check(rdata_r, 16'h0000);
    // Strap present at reset loads the pin code, a write overrides it
    @(posedge clk) strap_present <= 1'b1;
    do_reset();
    check({9'h000, cfg_r.valley_limit_amps}, 16'h0021);
    rd_chk(CMD_CURRENT_LIMIT, 16'h0003);
    rd_chk(CMD_TRIM_OFFSET, 16'h0000);
    wr_cfg(CMD_CURRENT_LIMIT, 16'h0005);
    rd_chk(CMD_CURRENT_LIMIT, 16'h0005);
    give_verdict();
  end
endmodule

// ### vmcr_sync.sv
// Two-flop synchroniser for the strap pin inputs.
// Assumes inputs are quasi-static pin levels, no bus coherence needed.
`timescale 1ns/1ps
module vmcr_sync #(
  parameter int WIDTH = 5
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             reset_n,
  // Pin side
  input  wire logic [WIDTH-1:0] pin_in,
  // Synchronised side
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1_r;
  logic [WIDTH-1:0] stage2_r;

  // Refused at elaboration, not at run time
  if (WIDTH < 1) begin : g_bad_width
    $error("vmcr_sync needs WIDTH of at least 1");
  end

  // First stage feeds only the second stage
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      stage1_r <= '0;
      stage2_r <= '0;
    end else begin
      stage1_r <= pin_in;
      stage2_r <= stage1_r;
    end
  end

  assign sync_out = stage2_r;

endmodule
